//--- verilog/scoc_top.sv
// Notes on behaviour
// - control, delay and pulse settings writable only with a channel in synchrocheck mode
// - five node modes, on after reset
// - force setting overrides stage status blocked or ok
// - select bus-measured or line-measured reference side
// - ok output continuous, delayed continuous, delayed pulse
// - delayed ok after programmable 5 ms-step delay
// - delayed pulse ends after programmable pulse length
// - three stages individually enabled, all off default
// - always mode checks without start input
// - blocking sampled each program cycle; ok only unblocked
// - blocked output instead of ok; active ok resets
`include "scoc_defines.svh"

module scoc_top
	import scoc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `SCOC_TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [1:0]  chan_sync_mode,
	input  wire logic [2:0]  sync_met,
	input  wire logic [2:0]  stage_start_input,
	input  wire logic [2:0]  block_input,
	output logic [2:0]       sync_ok_output,
	output logic [2:0]       stage_blocked,
	output logic             bus_is_measured_n,
	output logic             test_mode,
	output logic             irq
);
	scoc_state_s q_ff;
	scoc_state_s nxt_q;

	// defaults and time limit counted in program ticks; TICK_LAST counted in clock cycles
	localparam logic [18:0] DLY_DEF   = 19'(`SCOC_DELAY_DEF);
	localparam logic [18:0] PLS_DEF   = 19'(`SCOC_PULSE_DEF);
	localparam logic [18:0] TIME_MAX  = 19'(`SCOC_TIME_MAX);
	localparam logic [22:0] TICK_LAST = 23'(TICK_CYCLES - 1);

	logic        aw_hs;
	logic        w_hs;
	logic        ar_hs;
	logic        do_write;
	logic        cfg_open;
	logic [31:0] wd;
	logic [2:0]  force_blk;
	logic [2:0]  force_ok;
	logic [2:0]  run;
	logic        blk_mode;

	// every port below is read straight from the state register
	assign s_axi_awready = q_ff.bus.awready;
	assign s_axi_wready  = q_ff.bus.wready;
	assign s_axi_arready = q_ff.bus.arready;
	assign s_axi_bvalid  = q_ff.bus.bvalid;
	assign s_axi_bresp   = q_ff.bus.bresp;
	assign s_axi_rvalid  = q_ff.bus.rvalid;
	assign s_axi_rdata   = q_ff.bus.rdata;
	assign s_axi_rresp   = q_ff.bus.rresp;
	assign sync_ok_output    = q_ff.ok_out;
	assign stage_blocked     = q_ff.blk_out;
	assign bus_is_measured_n = q_ff.ref_out;
	assign test_mode         = q_ff.test_out;
	assign irq               = q_ff.irq;

	always_comb begin
		nxt_q    = q_ff;
		aw_hs    = s_axi_awvalid && s_axi_awready;
		w_hs     = s_axi_wvalid && s_axi_wready;
		ar_hs    = s_axi_arvalid && s_axi_arready;
		do_write = 1'b0;
		wd       = 32'h0;
		cfg_open = |q_ff.ss_s2;
		force_blk = 3'h0;
		force_ok  = 3'h0;
		run       = 3'h0;
		blk_mode  = 1'b0;

		// pin synchronisers
		nxt_q.blk_s1   = block_input;
		nxt_q.blk_s2   = q_ff.blk_s1;
		nxt_q.sync_s1  = sync_met;
		nxt_q.sync_s2  = q_ff.sync_s1;
		nxt_q.start_s1 = stage_start_input;
		nxt_q.start_s2 = q_ff.start_s1;
		nxt_q.ss_s1    = chan_sync_mode;
		nxt_q.ss_s2    = q_ff.ss_s1;

		// program-cycle tick
		nxt_q.tick = 1'b0;
		if (q_ff.tick_cnt == TICK_LAST) begin
			nxt_q.tick_cnt = 23'h0;
			nxt_q.tick     = 1'b1;
		end else begin
			nxt_q.tick_cnt = q_ff.tick_cnt + 23'h1;
		end

		// write channel
		// a write commits one cycle after address and data are both held
		if (aw_hs) begin
			nxt_q.bus.aw_got = 1'b1;
			nxt_q.bus.awaddr = s_axi_awaddr;
		end
		if (w_hs) begin
			nxt_q.bus.w_got = 1'b1;
			nxt_q.bus.wdata = s_axi_wdata;
			nxt_q.bus.wstrb = s_axi_wstrb;
		end
		if (q_ff.bus.aw_got && q_ff.bus.w_got) begin
			do_write         = 1'b1;
			nxt_q.bus.aw_got = 1'b0;
			nxt_q.bus.w_got  = 1'b0;
			nxt_q.bus.bvalid = 1'b1;
			nxt_q.bus.bresp  = 2'b00;
		end
		if (q_ff.bus.bvalid && s_axi_bready) begin
			nxt_q.bus.bvalid = 1'b0;
		end
		for (int i = 0; i < 4; i++) begin
			wd[i*8 +: 8] = q_ff.bus.wstrb[i] ? q_ff.bus.wdata[i*8 +: 8] : 8'h0;
		end

		if (do_write) begin
			// locked settings answer with a slave error and keep their values
			case ({7'h0, q_ff.bus.awaddr})
				`SCOC_OFS_CTRL: begin
					if (cfg_open) begin
						// out-of-range codes keep the previous setting
						if (wd[`SCOC_CTRL_MODE_LSB +: 3] <= 3'h4) begin
							nxt_q.cfg.mode = scoc_mode_e'(wd[`SCOC_CTRL_MODE_LSB +: 3]);
						end
						if (wd[`SCOC_CTRL_FORCE_LSB +: 3] <= 3'h6) begin
							nxt_q.cfg.force_sel = scoc_force_e'(wd[`SCOC_CTRL_FORCE_LSB +: 3]);
						end
						nxt_q.cfg.ref_line = wd[`SCOC_CTRL_REF_BIT];
						if (wd[`SCOC_CTRL_SHAPE_LSB +: 2] != 2'h3) begin
							nxt_q.cfg.shape = scoc_shape_e'(wd[`SCOC_CTRL_SHAPE_LSB +: 2]);
						end
						nxt_q.cfg.stage_enable       = wd[`SCOC_CTRL_EN_LSB +: 3];
						nxt_q.cfg.stage_start_gating = wd[`SCOC_CTRL_GATE_LSB +: 3];
					end else begin
						nxt_q.bus.bresp = 2'b10;
					end
				end
				`SCOC_OFS_DELAY: begin
					if (cfg_open && wd[18:0] <= TIME_MAX) begin
						nxt_q.cfg.delay = wd[18:0];
					end else begin
						nxt_q.bus.bresp = 2'b10;
					end
				end
				`SCOC_OFS_PULSE: begin
					if (cfg_open && wd[18:0] <= TIME_MAX) begin
						nxt_q.cfg.pulse = wd[18:0];
					end else begin
						nxt_q.bus.bresp = 2'b10;
					end
				end
				`SCOC_OFS_IRQ_EN: begin
					nxt_q.cfg.irq_en = wd[2:0];
				end
				`SCOC_OFS_IRQ_CLR: begin
					nxt_q.cfg.irq_stat = q_ff.cfg.irq_stat & ~wd[5:0];
				end
				`SCOC_OFS_STATUS, `SCOC_OFS_IRQ_STAT: begin
				end
				default: begin
					nxt_q.bus.bresp = 2'b10;
				end
			endcase
		end

		// read channel
		if (ar_hs) begin
			nxt_q.bus.rvalid = 1'b1;
			nxt_q.bus.rresp  = 2'b00;
			// unmapped words read as zero with a slave error
			case ({7'h0, s_axi_araddr})
				`SCOC_OFS_CTRL: begin
					nxt_q.bus.rdata = {9'h0, q_ff.cfg.stage_start_gating, 1'b0, q_ff.cfg.stage_enable,
						2'h0, q_ff.cfg.shape, 3'h0, q_ff.cfg.ref_line, 1'b0, q_ff.cfg.force_sel,
						1'b0, q_ff.cfg.mode};
				end
				`SCOC_OFS_DELAY: begin
					nxt_q.bus.rdata = {13'h0, q_ff.cfg.delay};
				end
				`SCOC_OFS_PULSE: begin
					nxt_q.bus.rdata = {13'h0, q_ff.cfg.pulse};
				end
				`SCOC_OFS_STATUS: begin
					nxt_q.bus.rdata = {23'h0, cfg_open, 1'b0, q_ff.blk_out, 1'b0, q_ff.ok_out};
				end
				`SCOC_OFS_IRQ_STAT: begin
					nxt_q.bus.rdata = {26'h0, q_ff.cfg.irq_stat};
				end
				`SCOC_OFS_IRQ_EN: begin
					nxt_q.bus.rdata = {29'h0, q_ff.cfg.irq_en};
				end
				`SCOC_OFS_IRQ_CLR: begin
					nxt_q.bus.rdata = 32'h0;
				end
				default: begin
					nxt_q.bus.rdata = 32'h0;
					nxt_q.bus.rresp = 2'b10;
				end
			endcase
		end
		if (q_ff.bus.rvalid && s_axi_rready) begin
			nxt_q.bus.rvalid = 1'b0;
		end

		// readies leave flops; each reopens as soon as its channel is free
		nxt_q.bus.awready = !nxt_q.bus.aw_got && !nxt_q.bus.bvalid;
		nxt_q.bus.wready  = !nxt_q.bus.w_got && !nxt_q.bus.bvalid;
		nxt_q.bus.arready = !nxt_q.bus.rvalid;

		// force decode
		case (q_ff.cfg.force_sel)
			SCOC_FORCE_S1_BLK: force_blk = 3'b001;
			SCOC_FORCE_S1_OK:  force_ok  = 3'b001;
			SCOC_FORCE_S2_BLK: force_blk = 3'b010;
			SCOC_FORCE_S2_OK:  force_ok  = 3'b010;
			SCOC_FORCE_S3_BLK: force_blk = 3'b100;
			SCOC_FORCE_S3_OK:  force_ok  = 3'b100;
			default: begin
			end
		endcase
		blk_mode = (q_ff.cfg.mode == SCOC_MODE_BLOCKED) || (q_ff.cfg.mode == SCOC_MODE_TEST_BLK);

		// stage sequencing, once per program cycle
		if (q_ff.tick) begin
			nxt_q.blk_smp = q_ff.blk_s2 | {3{blk_mode}};
			for (int s = 0; s < 3; s++) begin
				run[s] = q_ff.cfg.stage_enable[s] && (q_ff.cfg.mode != SCOC_MODE_OFF)
					&& (!q_ff.cfg.stage_start_gating[s] || q_ff.start_s2[s]);
				nxt_q.stg[s].ok  = 1'b0;
				nxt_q.stg[s].blk = 1'b0;
				if (!run[s] || !q_ff.sync_s2[s]) begin
					nxt_q.stg[s].st  = SCOC_ST_IDLE;
					nxt_q.stg[s].cnt = 19'h0;
				end else begin
					case (q_ff.stg[s].st)
						SCOC_ST_IDLE: begin
							// continuous shape or zero delay goes straight to ok
							nxt_q.stg[s].cnt = 19'h1;
							if (q_ff.cfg.shape == SCOC_SHAPE_CONT || q_ff.cfg.delay == 19'h0) begin
								nxt_q.stg[s].st = SCOC_ST_OK;
								nxt_q.stg[s].cnt = 19'h0;
							end else begin
								nxt_q.stg[s].st = SCOC_ST_WAIT;
							end
						end
						SCOC_ST_WAIT: begin
							nxt_q.stg[s].cnt = q_ff.stg[s].cnt + 19'h1;
							if (q_ff.stg[s].cnt >= q_ff.cfg.delay) begin
								nxt_q.stg[s].st  = SCOC_ST_OK;
								nxt_q.stg[s].cnt = 19'h0;
							end
						end
						SCOC_ST_OK: begin
							nxt_q.stg[s].cnt = q_ff.stg[s].cnt + 19'h1;
							if (q_ff.cfg.shape == SCOC_SHAPE_DLY_PULS
								&& q_ff.stg[s].cnt + 19'h1 >= q_ff.cfg.pulse) begin
								nxt_q.stg[s].st = SCOC_ST_DONE;
							end
						end
						SCOC_ST_DONE: begin
							// pulse spent: low until sync drops
						end
						default: begin
							nxt_q.stg[s].st = SCOC_ST_IDLE;
						end
					endcase
				end
				// blocking swaps ok for blocked; the timer keeps running
				if (nxt_q.stg[s].st == SCOC_ST_OK) begin
					if (nxt_q.blk_smp[s]) begin
						nxt_q.stg[s].blk = 1'b1;
					end else begin
						nxt_q.stg[s].ok = 1'b1;
					end
				end
			end
		end

		// outputs, with forcing on top
		// forcing acts within one clock, independent of the tick
		// rising edges set sticky flags; a set wins over a same-cycle clear
		for (int s = 0; s < 3; s++) begin
			nxt_q.ok_out[s]  = (q_ff.stg[s].ok && !force_blk[s]) || force_ok[s];
			nxt_q.blk_out[s] = (q_ff.stg[s].blk && !force_ok[s]) || force_blk[s];
			if (nxt_q.ok_out[s] && !q_ff.ok_out[s]) begin
				nxt_q.cfg.irq_stat[s] = 1'b1;
			end
			if (nxt_q.blk_out[s] && !q_ff.blk_out[s]) begin
				nxt_q.cfg.irq_stat[s+3] = 1'b1;
			end
		end
		nxt_q.ref_out  = q_ff.cfg.ref_line;
		nxt_q.test_out = (q_ff.cfg.mode == SCOC_MODE_TEST) || (q_ff.cfg.mode == SCOC_MODE_TEST_BLK);
		nxt_q.irq = |(q_ff.cfg.irq_stat & {q_ff.cfg.irq_en, q_ff.cfg.irq_en});
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q_ff                 <= '0;
			q_ff.cfg.mode        <= SCOC_MODE_ON;
			q_ff.cfg.force_sel   <= SCOC_FORCE_NORMAL;
			q_ff.cfg.shape       <= SCOC_SHAPE_CONT;
			q_ff.cfg.delay       <= DLY_DEF;
			q_ff.cfg.pulse       <= PLS_DEF;
			q_ff.bus.awready     <= 1'b1;
			q_ff.bus.wready      <= 1'b1;
			q_ff.bus.arready     <= 1'b1;
			for (int s = 0; s < 3; s++) begin
				q_ff.stg[s].st <= SCOC_ST_IDLE;
			end
		end else begin
			q_ff <= nxt_q;
		end
	end
endmodule // scoc_top

//--- verilog/scoc_defines.svh
`ifndef SCOC_DEFINES_SVH
`define SCOC_DEFINES_SVH

// register byte offsets
`define SCOC_OFS_CTRL      12'h000
`define SCOC_OFS_DELAY     12'h004
`define SCOC_OFS_PULSE     12'h008
`define SCOC_OFS_STATUS    12'h00c
`define SCOC_OFS_IRQ_STAT  12'h010
`define SCOC_OFS_IRQ_EN    12'h014
`define SCOC_OFS_IRQ_CLR   12'h018

// control register fields
`define SCOC_CTRL_MODE_LSB   0
`define SCOC_CTRL_FORCE_LSB  4
`define SCOC_CTRL_REF_BIT    8
`define SCOC_CTRL_SHAPE_LSB  12
`define SCOC_CTRL_EN_LSB     16
`define SCOC_CTRL_GATE_LSB   20

// timing: program-cycle step and defaults
`define SCOC_TICK_NS         5000000
`define SCOC_CLK_NS          10
`define SCOC_TICK_CYCLES     (`SCOC_TICK_NS / `SCOC_CLK_NS)
`define SCOC_DELAY_STEP_MS   5
`define SCOC_DELAY_DEF_MS    50
`define SCOC_DELAY_DEF       (`SCOC_DELAY_DEF_MS / `SCOC_DELAY_STEP_MS)
`define SCOC_PULSE_DEF       (`SCOC_DELAY_DEF_MS / `SCOC_DELAY_STEP_MS)
`define SCOC_TIME_MAX        360000

`endif

//--- verilog/scoc_pkg.sv
package scoc_pkg;
	typedef enum logic [2:0] {
		SCOC_MODE_ON       = 3'h0,
		SCOC_MODE_BLOCKED  = 3'h1,
		SCOC_MODE_TEST     = 3'h2,
		SCOC_MODE_TEST_BLK = 3'h3,
		SCOC_MODE_OFF      = 3'h4
	} scoc_mode_e;

	typedef enum logic [2:0] {
		SCOC_FORCE_NORMAL = 3'h0,
		SCOC_FORCE_S1_BLK = 3'h1,
		SCOC_FORCE_S1_OK  = 3'h2,
		SCOC_FORCE_S2_BLK = 3'h3,
		SCOC_FORCE_S2_OK  = 3'h4,
		SCOC_FORCE_S3_BLK = 3'h5,
		SCOC_FORCE_S3_OK  = 3'h6
	} scoc_force_e;

	typedef enum logic [1:0] {
		SCOC_SHAPE_CONT     = 2'h0,
		SCOC_SHAPE_DLY_CONT = 2'h1,
		SCOC_SHAPE_DLY_PULS = 2'h2
	} scoc_shape_e;

	typedef enum logic [1:0] {
		SCOC_ST_IDLE  = 2'h0,
		SCOC_ST_WAIT  = 2'h1,
		SCOC_ST_OK    = 2'h2,
		SCOC_ST_DONE  = 2'h3
	} scoc_stage_e;

	typedef struct packed {
		scoc_stage_e  st;
		logic [18:0]  cnt;
		logic         ok;
		logic         blk;
	} scoc_stage_s;

	typedef struct packed {
		logic [4:0]  awaddr;
		logic        aw_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        w_got;
		logic        bvalid;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [1:0]  bresp;
		logic        awready;
		logic        wready;
		logic        arready;
	} scoc_bus_s;

	typedef struct packed {
		scoc_mode_e  mode;
		scoc_force_e force_sel;
		logic        ref_line;
		scoc_shape_e shape;
		logic [2:0]  stage_enable;
		logic [2:0]  stage_start_gating;
		logic [18:0] delay;
		logic [18:0] pulse;
		logic [2:0]  irq_en;
		logic [5:0]  irq_stat;
	} scoc_cfg_s;

	typedef struct packed {
		scoc_bus_s       bus;
		scoc_cfg_s       cfg;
		scoc_stage_s [2:0] stg;
		logic [22:0]     tick_cnt;
		logic            tick;
		logic [2:0]      blk_s1;
		logic [2:0]      blk_s2;
		logic [2:0]      blk_smp;
		logic [2:0]      sync_s1;
		logic [2:0]      sync_s2;
		logic [2:0]      start_s1;
		logic [2:0]      start_s2;
		logic [1:0]      ss_s1;
		logic [1:0]      ss_s2;
		logic [2:0]      ok_out;
		logic [2:0]      blk_out;
		logic            ref_out;
		logic            test_out;
		logic            irq;
	} scoc_state_s;
endpackage

//--- sim/scoc_assertions.sv
module scoc_chk
	import scoc_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [4:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  chan_sync_mode,
	input wire logic [2:0]  sync_ok_output,
	input wire logic [2:0]  stage_blocked,
	input wire logic        bus_is_measured_n,
	input wire logic        test_mode,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] shut_ff;
	logic       wtake;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	assign wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	// mode pin must be low through the whole synchroniser
	always_ff @(posedge clk) shut_ff <= {shut_ff[1:0], chan_sync_mode == 2'h0};
	aw_stall_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write open during response");
	ar_stall_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read open during response");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rd_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	wr_ans_a: assert property (wtake |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	cfg_lock_a: assert property (wtake && &shut_ff && chan_sync_mode == 2'h0 && s_axi_awaddr < 5'h0c
		|-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h2) else $error("locked write accepted");
	ok_excl_a: assert property ((sync_ok_output & stage_blocked) == 3'h0)
		else $error("ok and blocked together");
	rst_out_a: assert property ($rose(reset_n) |-> sync_ok_output == 3'h0 && stage_blocked == 3'h0
		&& !bus_is_measured_n && !test_mode && !irq && !s_axi_bvalid) else $error("bad reset outputs");
endmodule // scoc_chk

bind scoc_top scoc_chk chk_i (.*);

//--- sim/scoc_relay.sv
module scoc_relay
	import scoc_pkg::*;
(
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic [2:0] sync_ok_output,
	input wire logic [2:0] start_req,
	output logic [2:0]     stage_start_input,
	output logic [7:0]     close_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] ok_ff;
	// start is a held level, not a pulse
	always_ff @(posedge clk) begin
		stage_start_input <= reset_n ? start_req : 3'h0;
		ok_ff <= sync_ok_output;
		close_cnt <= reset_n ? close_cnt + 8'(|(sync_ok_output & ~ok_ff)) : 8'h0;
	end
endmodule // scoc_relay

//--- sim/scoc_top_tb.sv
module scoc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import scoc_pkg::*;
	localparam int T = 8;
	logic clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bus_is_measured_n, test_mode, irq;
	logic [4:0] s_axi_awaddr, s_axi_araddr;
	logic [3:0] s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, chan_sync_mode, r;
	logic [2:0] sync_met, stage_start_input, block_input, sync_ok_output, stage_blocked, start_req;
	logic [7:0] close_cnt;
	int err_total, comparisons, n;
	scoc_top #(.TICK_CYCLES(T)) dut (.*);
	scoc_relay relay (.*);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task results();
		$display("checks %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task fail();
		err_total++;
		$display("BAD %0t wait ran out", $time);
		results();
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				return;
			end
		end
		fail();
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				return;
			end
		end
		fail();
	endtask
	// waits for ok (b=0) or blocked (b=1) of stage s to reach v
	task automatic wt(input int s, input logic b, input logic v);
		for (n = 0; n < 12 * T; n++) begin
			@(posedge clk);
			if ((b ? stage_blocked[s] : sync_ok_output[s]) === v) return;
		end
		fail();
	endtask
	function automatic logic [31:0] c(int sh, int en, int gt, int f = 0, int m = 0);
		return 32'(sh << 12 | en << 16 | gt << 20 | f << 4 | m);
	endfunction
	initial begin
		{reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, chan_sync_mode, sync_met, start_req, block_input} = '0;
		s_axi_wstrb = 4'hf;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		rd(5'h00);
		chk(d, 0);
		rd(5'h04);
		chk(d, 10);
		rd(5'h08);
		chk(d, 10);
		wr(5'h00, 32'h100);
		chk(r, 2'h2);
		chan_sync_mode <= 2'h2;
		repeat (3) @(posedge clk);
		wr(5'h00, 32'h100);
		chk(r, 2'h0);
		repeat (2) @(posedge clk);
		chk(bus_is_measured_n, 1);
		wr(5'h00, c(0, 1, 0));
		sync_met <= 3'h3;
		wt(0, 0, 1);
		chk(sync_ok_output[1], 0);
		block_input <= 3'h1;
		wt(0, 1, 1);
		chk(sync_ok_output[0], 0);
		{block_input, sync_met} <= '0;
		wr(5'h00, c(0, 2, 2));
		sync_met <= 3'h2;
		repeat (4 * T) @(posedge clk);
		chk(sync_ok_output[1], 0);
		start_req <= 3'h2;
		wt(1, 0, 1);
		{start_req, sync_met} <= '0;
		wr(5'h04, 32'h3);
		wr(5'h00, c(1, 1, 0));
		repeat (3 * T) @(posedge clk);
		sync_met <= 3'h1;
		wt(0, 0, 1);
		chk(n >= 3 * T && n <= 5 * T + 6, 1);
		sync_met <= 3'h0;
		wt(0, 0, 0);
		sync_met <= 3'h1;
		repeat (T) @(posedge clk);
		sync_met <= 3'h0;
		repeat (2 * T) @(posedge clk);
		sync_met <= 3'h1;
		wt(0, 0, 1);
		chk(n >= 3 * T, 1);
		sync_met <= 3'h0;
		wr(5'h08, 32'h2);
		wr(5'h00, c(2, 1, 0));
		repeat (3 * T) @(posedge clk);
		sync_met <= 3'h1;
		wt(0, 0, 1);
		wt(0, 0, 0);
		chk(n >= 2 * T - 2 && n <= 2 * T, 1);
		repeat (3 * T) @(posedge clk);
		chk(sync_ok_output[0], 0);
		sync_met <= 3'h0;
		for (int f = 1; f < 7; f++) begin
			wr(5'h00, c(0, 7, 0, f));
			repeat (3) @(posedge clk);
			chk(f % 2 ? stage_blocked[(f - 1) / 2] : sync_ok_output[(f - 1) / 2], 1);
		end
		sync_met <= 3'h7;
		for (int m = 0; m < 5; m++) begin
			wr(5'h00, c(0, 7, 0, 0, m));
			repeat (4 * T) @(posedge clk);
			chk(test_mode, m == 2 || m == 3);
			if (m == 0 || m == 4) chk(sync_ok_output, m == 0 ? 3'h7 : 3'h0);
			if (m == 1 || m == 3) chk(stage_blocked, 3'h7);
		end
		rd(5'h10);
		chk(d, 32'h3f);
		wr(5'h14, 32'h4);
		repeat (2) @(posedge clk);
		chk(irq, 1);
		wr(5'h18, 32'h3f);
		repeat (2) @(posedge clk);
		chk(irq, 0);
		rd(5'h10);
		chk(d, 0);
		rd(5'h0c);
		chk(d, 32'h100);
		rd(5'h1c);
		chk(r, 2'h2);
		chk(d, 0);
		wr(5'h04, 32'd360001);
		chk(r, 2'h2);
		rd(5'h04);
		chk(d, 3);
		chk(close_cnt > 0, 1);
		results();
	end
endmodule // scoc_top_tb
